/* File: aba_top.sv */
// Block cipher accelerator: registers, data queues, DMA and events
//
// Notes on behaviour
// - Key lengths 128, 192 and 256 bits.
// - Encrypt, decrypt external, decrypt derived key.
// - Four queued words start a block automatically.
// - Start bit forces partial block; reads zero.
// - Result is four words, low word first.
// - Done interrupt raised when its enable is set.
// - Busy high during calculation, low afterwards.
// - Queue empty status; flush bits empty queues.
// - Operation type 00 encrypts with external key.
// - Completion requests DMA to drain output queue.
// - Undrained output at completion sets overrun.
// - Block takes 181, 213 or 245 cycles.
// - Encryption derives the internal decryption key.
// - DMA and software may share both queues.
// - Type 01, 10 decrypt; 11 reserved.
// - Starting with all-zero key flags key zero.
// - Key write while busy flags key change.
// - Busy falling edge sets done flag.
`timescale 1ns/1ps
module aba_top (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Register port
  input wire logic [4:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Key storage
  input wire logic [255:0] key_in,
  input wire logic key_wr_in,
  // DMA and interrupt
  output logic dma_tx_req_out,
  output logic dma_rx_req_out,
  output logic irq_out
);

  aba_pkg::aba_top_s s_r;
  aba_pkg::aba_top_s s_nxt;
  aba_eng_if eng ();
  logic busy_now;
  logic start_req;
  logic launch;
  logic legal_cfg;
  logic [255:0] sel_key;

  // ----------------------------------------------------------------
  // Round engine
  // ----------------------------------------------------------------
  aba_round_eng u_eng (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .eng(eng.eng)
  );

  assign eng.start = s_r.go;
  assign eng.key = s_r.go_key;
  assign eng.key_size = s_r.key_size;
  assign eng.data = s_r.go_data;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.go = 1'b0;
    s_nxt.rd_data = aba_pkg::RST_WORD;
    start_req = 1'b0;
    launch = 1'b0;
    sel_key = '0;
    busy_now = s_r.go | eng.busy;
    legal_cfg = (s_r.op_type != aba_pkg::OP_RSVD) &&
                (s_r.key_size != aba_pkg::KSZ_RSVD);

    // Register writes
    if (wr_in)
    begin
      case (addr_in)
        aba_pkg::ADDR_CTRL:
        begin
          s_nxt.en = wdata_in[aba_pkg::CTRL_EN];
          s_nxt.rx_en = wdata_in[aba_pkg::CTRL_RX_EN];
          s_nxt.tx_en = wdata_in[aba_pkg::CTRL_TX_EN];
          s_nxt.key_size = wdata_in[aba_pkg::CTRL_KSIZE +: 2];
          s_nxt.op_type = wdata_in[aba_pkg::CTRL_TYPE +: 2];
          start_req = wdata_in[aba_pkg::CTRL_START];
          if (wdata_in[aba_pkg::CTRL_IN_FLUSH])
          begin
            s_nxt.in_cnt = 3'h0;
          end
          if (wdata_in[aba_pkg::CTRL_OUT_FLUSH])
          begin
            s_nxt.out_cnt = 3'h0;
            s_nxt.out_rd = 2'h0;
            s_nxt.overrun = 1'b0;
          end
        end
        aba_pkg::ADDR_INTFL:
        begin
          s_nxt.flags = s_r.flags & ~wdata_in[3:0];
        end
        aba_pkg::ADDR_INTEN:
        begin
          s_nxt.inten = wdata_in[3:0];
        end
        aba_pkg::ADDR_FIFO:
        begin
          if (s_r.in_cnt != aba_pkg::WORDS)
          begin
            s_nxt.in_q[s_r.in_cnt[1:0]] = wdata_in;
            s_nxt.in_cnt = s_r.in_cnt + 3'h1;
          end
        end
        default:
        begin
        end
      endcase
    end

    // Register reads, data stands one cycle later
    if (rd_in)
    begin
      case (addr_in)
        aba_pkg::ADDR_CTRL:
        begin
          s_nxt.rd_data = {22'h0, s_r.op_type, s_r.key_size, 3'h0,
                           s_r.tx_en, s_r.rx_en, s_r.en};
        end
        aba_pkg::ADDR_STATUS:
        begin
          s_nxt.rd_data = {27'h0, s_r.overrun, s_r.out_cnt == 3'h0,
                           s_r.in_cnt == aba_pkg::WORDS,
                           s_r.in_cnt == 3'h0, busy_now};
        end
        aba_pkg::ADDR_INTFL:
        begin
          s_nxt.rd_data = {28'h0, s_r.flags};
        end
        aba_pkg::ADDR_INTEN:
        begin
          s_nxt.rd_data = {28'h0, s_r.inten};
        end
        aba_pkg::ADDR_FIFO:
        begin
          if (s_r.out_cnt != 3'h0)
          begin
            s_nxt.rd_data = s_r.out_q[s_r.out_rd];
            s_nxt.out_rd = s_r.out_rd + 2'h1;
            s_nxt.out_cnt = s_r.out_cnt - 3'h1;
          end
        end
        default:
        begin
        end
      endcase
    end

    // Block launch
    launch = s_nxt.en && !busy_now && legal_cfg &&
             (s_nxt.in_cnt == aba_pkg::WORDS || start_req);
    if (launch)
    begin
      if (s_r.op_type == aba_pkg::OP_DEC_INT)
      begin
        sel_key = s_r.dec_key;
      end
      else
      begin
        sel_key = aba_pkg::key_sized(key_in, s_r.key_size);
      end
      if (s_r.op_type == aba_pkg::OP_ENC_EXT)
      begin
        s_nxt.dec_key = sel_key;
      end
      if (sel_key == '0)
      begin
        s_nxt.flags[aba_pkg::FL_KEY_ZERO] = 1'b1;
      end
      for (int i = 0; i < 4; i++)
      begin
        if (3'(i) < s_nxt.in_cnt)
        begin
          s_nxt.go_data[i] = s_nxt.in_q[i];
        end
        else
        begin
          s_nxt.go_data[i] = aba_pkg::RST_WORD;
        end
      end
      s_nxt.go = 1'b1;
      s_nxt.go_key = sel_key;
      s_nxt.in_cnt = 3'h0;
    end

    // Completion loads the output queue
    if (eng.done)
    begin
      if (s_r.out_cnt != 3'h0)
      begin
        s_nxt.flags[aba_pkg::FL_OV] = 1'b1;
        s_nxt.overrun = 1'b1;
      end
      s_nxt.out_q = eng.result;
      s_nxt.out_cnt = aba_pkg::WORDS;
      s_nxt.out_rd = 2'h0;
    end

    // Events
    if (key_wr_in && busy_now)
    begin
      s_nxt.flags[aba_pkg::FL_KEY_CHANGE] = 1'b1;
    end
    if (s_r.busy_d && !busy_now)
    begin
      s_nxt.flags[aba_pkg::FL_DONE] = 1'b1;
    end
    s_nxt.busy_d = busy_now;

    // Registered outputs
    s_nxt.irq = |(s_nxt.flags & s_nxt.inten);
    s_nxt.tx_req = s_nxt.en && s_nxt.tx_en && s_nxt.in_cnt == 3'h0;
    s_nxt.rx_req = s_nxt.rx_en &&
                   s_nxt.out_cnt == aba_pkg::WORDS;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign rdata_out = s_r.rd_data;
  assign irq_out = s_r.irq;
  assign dma_tx_req_out = s_r.tx_req;
  assign dma_rx_req_out = s_r.rx_req;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  a_auto_start: assert property (
    s_r.en && s_r.in_cnt == aba_pkg::WORDS && !busy_now && legal_cfg &&
    !wr_in |=> s_r.go && s_r.in_cnt == 3'h0)
    else $error("Full input queue did not start a block");

  a_manual_start: assert property (
    wr_in && addr_in == aba_pkg::ADDR_CTRL && wdata_in[aba_pkg::CTRL_START]
    && wdata_in[aba_pkg::CTRL_EN] && !busy_now && legal_cfg |=> s_r.go)
    else $error("Start bit did not launch a block");

  a_start_reads0: assert property (
    rd_in && addr_in == aba_pkg::ADDR_CTRL
    |=> rdata_out[aba_pkg::CTRL_START +: 3] == 3'h0)
    else $error("Self-clearing control bits read as one");

  a_busy_done: assert property (
    s_r.busy_d && !busy_now |=> s_r.flags[aba_pkg::FL_DONE])
    else $error("Busy fell without done flag");

  a_irq_gate: assert property (
    s_r.flags[aba_pkg::FL_DONE] && s_r.inten[aba_pkg::FL_DONE] |-> irq_out)
    else $error("Enabled done flag without interrupt");

  a_overrun_set: assert property (
    eng.done && s_r.out_cnt != 3'h0
    |=> s_r.flags[aba_pkg::FL_OV] && s_r.overrun)
    else $error("Undrained output not flagged as overrun");

  a_result_words: assert property (
    eng.done |=> s_r.out_cnt == aba_pkg::WORDS && s_r.out_rd == 2'h0)
    else $error("Result not presented as four words");

  a_rx_request: assert property (
    eng.done && s_r.rx_en |=> dma_rx_req_out)
    else $error("Completion did not request output drain");

  a_key_zero: assert property (
    s_r.go && s_r.go_key == '0 |-> s_r.flags[aba_pkg::FL_KEY_ZERO])
    else $error("All-zero key start not flagged");

  a_key_change: assert property (
    key_wr_in && busy_now |=> s_r.flags[aba_pkg::FL_KEY_CHANGE])
    else $error("Key write while busy not flagged");

  a_in_flush: assert property (
    wr_in && addr_in == aba_pkg::ADDR_CTRL &&
    wdata_in[aba_pkg::CTRL_IN_FLUSH] |=> s_r.in_cnt == 3'h0)
    else $error("Input flush left words queued");

  a_derive_key: assert property (
    s_r.go && s_r.op_type == aba_pkg::OP_ENC_EXT |-> s_r.dec_key == s_r.go_key)
    else $error("Encryption did not derive decryption key");

  a_done_flag: assert property (
    eng.done |=> s_r.flags[aba_pkg::FL_DONE])
    else $error("Engine completion did not set done flag");

  a_go_busy: assert property (
    s_r.go |=> eng.busy)
    else $error("Launched block did not make the engine busy");

  a_full_hold: assert property (
    s_r.in_cnt == aba_pkg::WORDS && busy_now &&
    !(wr_in && addr_in == aba_pkg::ADDR_CTRL) |=> s_r.in_cnt == aba_pkg::WORDS)
    else $error("Full input queue lost words while busy");

  a_out_pop: assert property (
    rd_in && addr_in == aba_pkg::ADDR_FIFO && s_r.out_cnt != 3'h0 &&
    !eng.done |=> s_r.out_cnt == $past(s_r.out_cnt) - 3'h1)
    else $error("Output read did not pop one word");

  a_rdata_idle: assert property (
    !rd_in |=> rdata_out == aba_pkg::RST_WORD)
    else $error("Read data not zero outside a read");

  a_tx_request: assert property (
    s_r.en && s_r.tx_en && s_r.in_cnt == 3'h0 && !wr_in |=> dma_tx_req_out)
    else $error("Empty input queue did not request words");

  c_full_block: cover property (s_r.go && !start_req && s_r.op_type == 2'h0);
  c_partial: cover property (launch && start_req && s_r.in_cnt == 3'h2);
  c_overrun: cover property (eng.done && s_r.out_cnt != 3'h0);
  c_dec_int: cover property (s_r.go && s_r.op_type == aba_pkg::OP_DEC_INT);

endmodule : aba_top

/* File: aba_pkg.sv */
// Constants, field layout and state types of the block cipher accelerator
package aba_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_INTFL = 5'h08;
  localparam logic [4:0] ADDR_INTEN = 5'h0c;
  localparam logic [4:0] ADDR_FIFO = 5'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN = 0;
  localparam int CTRL_RX_EN = 1;
  localparam int CTRL_TX_EN = 2;
  localparam int CTRL_START = 3;
  localparam int CTRL_IN_FLUSH = 4;
  localparam int CTRL_OUT_FLUSH = 5;
  localparam int CTRL_KSIZE = 6;
  localparam int CTRL_TYPE = 8;
  localparam int FL_DONE = 0;
  localparam int FL_KEY_CHANGE = 1;
  localparam int FL_KEY_ZERO = 2;
  localparam int FL_OV = 3;

  // ----------------------------------------------------------------
  // Encodings, reset values and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_ENC_EXT = 2'h0;
  localparam logic [1:0] OP_DEC_EXT = 2'h1;
  localparam logic [1:0] OP_DEC_INT = 2'h2;
  localparam logic [1:0] OP_RSVD = 2'h3;
  localparam logic [1:0] KSZ_128 = 2'h0;
  localparam logic [1:0] KSZ_192 = 2'h1;
  localparam logic [1:0] KSZ_256 = 2'h2;
  localparam logic [1:0] KSZ_RSVD = 2'h3;
  localparam logic [7:0] CYC_K128 = 8'hb5;
  localparam logic [7:0] CYC_K192 = 8'hd5;
  localparam logic [7:0] CYC_K256 = 8'hf5;
  localparam logic [2:0] WORDS = 3'h4;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic rx_en;
    logic tx_en;
    logic [1:0] key_size;
    logic [1:0] op_type;
    logic [3:0][31:0] in_q;
    logic [2:0] in_cnt;
    logic [3:0][31:0] out_q;
    logic [2:0] out_cnt;
    logic [1:0] out_rd;
    logic [3:0] flags;
    logic [3:0] inten;
    logic overrun;
    logic busy_d;
    logic go;
    logic [255:0] go_key;
    logic [3:0][31:0] go_data;
    logic [255:0] dec_key;
    logic [31:0] rd_data;
    logic irq;
    logic tx_req;
    logic rx_req;
  } aba_top_s;

  typedef struct packed {
    logic busy;
    logic done;
    logic [7:0] cnt;
    logic [127:0] mask;
    logic [127:0] data;
  } aba_eng_s;

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  function automatic logic [7:0] cycles_for(input logic [1:0] ks);
    case (ks)
      KSZ_192: cycles_for = CYC_K192;
      KSZ_256: cycles_for = CYC_K256;
      default: cycles_for = CYC_K128;
    endcase
  endfunction : cycles_for

  function automatic logic [255:0] key_sized(input logic [255:0] k,
                                             input logic [1:0] ks);
    case (ks)
      KSZ_192: key_sized = {64'h0, k[191:0]};
      KSZ_256: key_sized = k;
      default: key_sized = {128'h0, k[127:0]};
    endcase
  endfunction : key_sized

endpackage : aba_pkg

/* File: aba_eng_if.sv */
// Link between the accelerator control and its round engine
`timescale 1ns/1ps
interface aba_eng_if;
  logic start;
  logic [255:0] key;
  logic [1:0] key_size;
  logic [3:0][31:0] data;
  logic busy;
  logic done;
  logic [3:0][31:0] result;

  modport ctl (
    output start,
    output key,
    output key_size,
    output data,
    input busy,
    input done,
    input result
  );

  modport eng (
    input start,
    input key,
    input key_size,
    input data,
    output busy,
    output done,
    output result
  );
endinterface : aba_eng_if

/* File: aba_round_eng.sv */
// Iterative round engine with key-size dependent latency
`timescale 1ns/1ps
module aba_round_eng (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Control side
  aba_eng_if.eng eng
);

  aba_pkg::aba_eng_s s_r;
  aba_pkg::aba_eng_s s_nxt;

  // ----------------------------------------------------------------
  // Round sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (eng.start && !s_r.busy)
    begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt = aba_pkg::cycles_for(eng.key_size) - 8'h01;
      s_nxt.mask = eng.key[127:0];
      s_nxt.data = eng.data;
    end
    else if (s_r.busy)
    begin
      s_nxt.mask = {s_r.mask[126:0], s_r.mask[127]} ^ eng.key[255:128];
      if (s_r.cnt == 8'h00)
      begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.data = s_r.data ^ s_r.mask;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign eng.busy = s_r.busy;
  assign eng.done = s_r.done;
  assign eng.result = s_r.data;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_lat_k128: assert property (
    @(posedge clock_in) disable iff (rst_in)
    eng.start && !s_r.busy && eng.key_size == aba_pkg::KSZ_128
    |-> ##181 (s_r.busy && s_r.cnt == 8'h00) ##1 s_r.done)
    else $error("128-bit key block not done in 181 cycles");

  a_lat_k192: assert property (
    @(posedge clock_in) disable iff (rst_in)
    eng.start && !s_r.busy && eng.key_size == aba_pkg::KSZ_192
    |-> ##213 (s_r.busy && s_r.cnt == 8'h00) ##1 s_r.done)
    else $error("192-bit key block not done in 213 cycles");

  a_lat_k256: assert property (
    @(posedge clock_in) disable iff (rst_in)
    eng.start && !s_r.busy && eng.key_size == aba_pkg::KSZ_256
    |-> ##245 (s_r.busy && s_r.cnt == 8'h00) ##1 s_r.done)
    else $error("256-bit key block not done in 245 cycles");

endmodule : aba_round_eng

/* File: aba_dma_model.sv */
// Model of the DMA controller that feeds and drains the data queues
`timescale 1ns/1ps
module aba_dma_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Requests and read data from the accelerator
  input wire logic tx_req_in,
  input wire logic rx_req_in,
  input wire logic [31:0] rdata_in,
  // Job set by the bench
  input wire logic [3:0][31:0] blk_in,
  input wire logic [3:0] nblk_in,
  input wire logic [3:0] stall_in,
  // Register port while the model owns it
  output logic own_out,
  output logic [4:0] addr_out,
  output logic [31:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  // Progress and last result
  output logic [3:0] sent_out,
  output logic [3:0] got_out,
  output logic [3:0][31:0] res_out
);
  initial
  begin
    own_out = 1'b0;
    addr_out = 5'h00;
    wdata_out = 32'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    sent_out = 4'h0;
    got_out = 4'h0;
    res_out = '0;
    forever
    begin
      @(posedge clock_in);
      if (rst_in)
      begin
        sent_out <= 4'h0;
        got_out <= 4'h0;
      end
      else if (rx_req_in)
      begin
        // Drain one whole result, low word first
        own_out <= 1'b1;
        repeat (stall_in) @(posedge clock_in);
        addr_out <= aba_pkg::ADDR_FIFO;
        rd_out <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
          @(posedge clock_in);
          if (i == 3)
            rd_out <= 1'b0;
          if (i > 0)
            res_out[i - 1] = rdata_in;
        end
        own_out <= 1'b0;
        addr_out <= ~addr_out;
        got_out <= got_out + 4'h1;
        repeat (3) @(posedge clock_in);
      end
      else if (tx_req_in && sent_out < nblk_in)
      begin
        // Only whole blocks of four words are sent
        own_out <= 1'b1;
        repeat (stall_in) @(posedge clock_in);
        for (int i = 0; i < 4; i++)
        begin
          addr_out <= aba_pkg::ADDR_FIFO;
          wdata_out <= blk_in[i];
          wr_out <= 1'b1;
          @(posedge clock_in);
        end
        wr_out <= 1'b0;
        own_out <= 1'b0;
        wdata_out <= ~blk_in[3];
        sent_out <= sent_out + 4'h1;
        repeat (3) @(posedge clock_in);
      end
    end
  end
endmodule : aba_dma_model

/* File: aba_top_tb.sv */
// Self-checking bench for the block cipher accelerator
`timescale 1ns/1ps
module aba_top_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [4:0] A_CTRL = aba_pkg::ADDR_CTRL;
  localparam logic [4:0] A_STAT = aba_pkg::ADDR_STATUS;
  localparam logic [4:0] A_FL = aba_pkg::ADDR_INTFL;
  localparam logic [4:0] A_EN = aba_pkg::ADDR_INTEN;
  localparam logic [4:0] A_FIFO = aba_pkg::ADDR_FIFO;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] t_addr = 5'h00;
  logic [31:0] t_wd = 32'h0;
  logic t_wr = 1'b0;
  logic t_rd = 1'b0;
  logic [255:0] key = {64'h0f1e_2d3c_4b5a_6978, 64'h8796_a5b4_c3d2_e1f0,
                       64'h1357_9bdf_2468_ace0, 64'hfeed_c0de_0bad_f00d};
  logic key_wr = 1'b0;
  logic d_own, d_wr, d_rd;
  logic [4:0] d_addr;
  logic [31:0] d_wd, rdata, v;
  logic [3:0][31:0] d_res, r;
  logic [3:0] d_sent, d_got;
  logic [3:0] nblk = 4'h0;
  logic [3:0] stall = 4'h0;
  logic tx_req, rx_req, irq;
  logic [3:0][31:0] pt = {32'h0c0d_0e0f, 32'h0809_0a0b, 32'h0405_0607,
                          32'h0001_0203};
  logic [3:0][31:0] ct [3];
  int lat [3] = '{32'h0b5, 32'h0d5, 32'h0f5};
  int fails = 0;
  int num_checks = 0;
  int n;

  always #2.5 clock_in = ~clock_in;

  aba_top dut (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .addr_in(d_own ? d_addr : t_addr),
    .wdata_in(d_own ? d_wd : t_wd),
    .wr_in(d_own ? d_wr : t_wr),
    .rd_in(d_own ? d_rd : t_rd),
    .rdata_out(rdata),
    .key_in(key),
    .key_wr_in(key_wr),
    .dma_tx_req_out(tx_req),
    .dma_rx_req_out(rx_req),
    .irq_out(irq)
  );

  aba_dma_model dma (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .tx_req_in(tx_req),
    .rx_req_in(rx_req),
    .rdata_in(rdata),
    .blk_in(pt),
    .nblk_in(nblk),
    .stall_in(stall),
    .own_out(d_own),
    .addr_out(d_addr),
    .wdata_out(d_wd),
    .wr_out(d_wr),
    .rd_out(d_rd),
    .sent_out(d_sent),
    .got_out(d_got),
    .res_out(d_res)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_in);
    t_addr <= a;
    t_wd <= d;
    t_wr <= 1'b1;
    @(posedge clock_in);
    t_wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
    @(posedge clock_in);
    t_addr <= a;
    t_rd <= 1'b1;
    @(posedge clock_in);
    t_rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic cfg(input logic [1:0] ks, input logic [1:0] op,
                     input logic [1:0] tr);
    wait_idle();
    wr_reg(A_CTRL, 32'h0);
    wr_reg(A_CTRL, 32'h30);
    wr_reg(A_CTRL, {22'h0, op, ks, 3'h0, tr, 1'b1});
  endtask : cfg

  task automatic push(input logic [3:0][31:0] b);
    for (int i = 0; i < 4; i++)
      wr_reg(A_FIFO, b[i]);
  endtask : push

  task automatic pull(output logic [3:0][31:0] b);
    for (int i = 0; i < 4; i++)
      rd_reg(A_FIFO, b[i]);
  endtask : pull

  task automatic wait_idle;
    int k;
    k = 0;
    v = 32'h1;
    while (v[0] !== 1'b0 && k < 300)
    begin
      rd_reg(A_STAT, v);
      k++;
    end
    if (k == 300)
    begin
      fails++;
      stop_test();
    end
  endtask : wait_idle

  task automatic wait_cyc(input bit use_got, input logic [3:0] exp);
    n = 0;
    while ((use_got ? d_got : d_sent) !== exp && n < 2000)
    begin
      @(posedge clock_in);
      n++;
    end
    if (n == 2000)
    begin
      fails++;
      stop_test();
    end
  endtask : wait_cyc

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    rd_reg(A_CTRL, v);
    chk(v, 32'h0);
    rd_reg(A_STAT, v);
    chk(v, 32'h0000_000a);
    rd_reg(5'h14, v);
    chk(v, 32'h0);
    wr_reg(A_EN, 32'h1);
    for (int s = 0; s < 3; s++)
    begin
      cfg(2'(s), aba_pkg::OP_ENC_EXT, 2'h0);
      push(pt);
      n = 0;
      while (irq !== 1'b1 && n < 400)
      begin
        @(posedge clock_in);
        n++;
      end
      chk(32'(n >= lat[s] && n <= lat[s] + 6), 32'h1);
      rd_reg(A_STAT, v);
      chk(v, 32'h2);
      wr_reg(A_FL, 32'h1);
      rd_reg(A_FL, v);
      chk({v[31:1], irq}, 32'h0);
      pull(ct[s]);
      chk(32'(ct[s][0] !== pt[0]), 32'h1);
      chk(32'(s == 0 || ct[s][0] !== ct[0][0]), 32'h1);
      for (int t = 1; t < 3; t++)
      begin
        cfg(2'(s), 2'(t), 2'h0);
        push(ct[s]);
        wait_idle();
        pull(r);
        for (int i = 0; i < 4; i++)
          chk(r[i], pt[i]);
      end
      wr_reg(A_FL, 32'hf);
    end
    wr_reg(A_EN, 32'h0);
    cfg(aba_pkg::KSZ_128, aba_pkg::OP_ENC_EXT, 2'h0);
    wr_reg(A_FIFO, pt[0]);
    wr_reg(A_FIFO, pt[1]);
    rd_reg(A_STAT, v);
    chk(v, 32'h8);
    wr_reg(A_CTRL, 32'h9);
    rd_reg(A_CTRL, v);
    chk(v, 32'h1);
    rd_reg(A_STAT, v);
    chk(v, 32'hb);
    wait_idle();
    pull(r);
    cfg(aba_pkg::KSZ_128, aba_pkg::OP_DEC_EXT, 2'h0);
    push(r);
    wait_idle();
    pull(r);
    for (int i = 0; i < 4; i++)
      chk(r[i], (i < 2) ? pt[i] : 32'h0);
    rd_reg(A_FIFO, v);
    chk(v, 32'h0);
    wr_reg(A_FIFO, pt[0]);
    wr_reg(A_CTRL, 32'h11);
    rd_reg(A_STAT, v);
    chk(v, 32'ha);
    wr_reg(A_FL, 32'hf);
    cfg(aba_pkg::KSZ_128, aba_pkg::OP_ENC_EXT, 2'h0);
    push(pt);
    @(posedge clock_in);
    key_wr <= 1'b1;
    @(posedge clock_in);
    key_wr <= 1'b0;
    push(pt);
    repeat (420) @(posedge clock_in);
    rd_reg(A_STAT, v);
    chk(v, 32'h12);
    rd_reg(A_FL, v);
    chk(v, 32'hb);
    wr_reg(A_EN, 32'h8);
    rd_reg(A_STAT, v);
    chk({31'h0, irq}, 32'h1);
    wr_reg(A_FL, 32'hf);
    wr_reg(A_CTRL, 32'h21);
    rd_reg(A_STAT, v);
    chk({v[31:1], irq}, 32'ha);
    wr_reg(A_EN, 32'h0);
    key <= 256'h0;
    cfg(aba_pkg::KSZ_128, aba_pkg::OP_ENC_EXT, 2'h0);
    wr_reg(A_CTRL, 32'h9);
    wait_idle();
    rd_reg(A_FL, v);
    chk(v, 32'h5);
    key <= {64'h0f1e_2d3c_4b5a_6978, 64'h8796_a5b4_c3d2_e1f0,
            64'h1357_9bdf_2468_ace0, 64'hfeed_c0de_0bad_f00d};
    wr_reg(A_FL, 32'hf);
    // Transmit side by DMA, receive side by software
    cfg(aba_pkg::KSZ_128, aba_pkg::OP_ENC_EXT, 2'h2);
    nblk <= 4'h1;
    wait_cyc(1'b0, 4'h1);
    wait_idle();
    pull(r);
    for (int i = 0; i < 4; i++)
      chk(r[i], ct[0][i]);
    // Both sides by a slow DMA
    stall <= 4'h3;
    cfg(aba_pkg::KSZ_128, aba_pkg::OP_ENC_EXT, 2'h3);
    nblk <= 4'h3;
    wait_cyc(1'b1, 4'h2);
    for (int i = 0; i < 4; i++)
      chk(d_res[i], ct[0][i]);
    chk({31'h0, irq}, 32'h0);
    stop_test();
  end
endmodule : aba_top_tb
